// *** hw/bafe_status_regs.sv ***
// Status, user flag and analog output selector register group
`timescale 1ns/1ps
//
// Overview of operation
// - Single-unit bit fixed, ignores writes
// - Wake polarity high: bit follows pin
// - Wake polarity low: bit inverts pin
// - External overtemp latched, read clears once gone
// - Internal overtemp latched, read clears once gone
// - Load fail latched when monitoring, heavy and a discharge event
// - Discharge short latched, read clears once gone
// - Discharge overcurrent latched, read clears once gone
// - Charge overcurrent latched, read clears once gone
// - Two user flags kept on backup supply
// - Selector decodes off, cells, temperatures, reserved
// - Load monitor follows its enable bit
// - Forced sleep leaves selector unchanged
module bafe_status_regs (
    input  wire logic                 clk,            // 200 MHz clock
    input  wire logic                 rst,            // Sync reset
    input  wire logic [7:0]           regAddr,        // Register address
    input  wire logic                 regWrite,       // Write strobe
    input  wire logic [7:0]           regWdata,       // Write data
    input  wire logic                 regRead,        // Read strobe
    output logic [7:0]                regRdata,       // Read data
    input  wire logic                 wakePin,        // Wake comparator
    input  wire logic                 wakePolarity,   // Wake polarity
    input  wire logic                 extOvertemp,    // Thermistor hot
    input  wire logic                 intOvertemp,    // Die sensor hot
    input  wire logic                 dischargeShort, // Short detected
    input  wire logic                 dischargeOc,    // Discharge OC
    input  wire logic                 chargeOc,       // Charge OC
    input  wire logic                 loadHeavy,      // Load stays heavy
    input  wire logic                 loadMonitorEnable, // Monitor on
    input  wire logic                 forceSleep,     // Sleep request
    output logic                      loadMonitorOn,  // Monitor power
    output logic [3:0]                analogSelect,   // Selector bits
    output bafe_pkg::bafe_route_t     analogRoute,    // One-hot route
    output logic                      analogReserved, // Reserved code
    output logic [1:0]                userFlags       // Flags b,a
);
    import bafe_pkg::*;

    // ***************************************************************
    // State
    // ***************************************************************
    typedef struct packed {
        logic [9:0]  syncA;      // First synchroniser stage
        logic [9:0]  syncB;      // Second synchroniser stage
        logic [1:0]  userFlags;
        logic [3:0]  muxSel;
        logic [7:0]  rdata;
        bafe_route_t route;
        logic        reserved;
        logic        monOn;
    } bafe_state_s;

    bafe_state_s state_reg;
    bafe_state_s state_next;

    logic [9:0] rawIn;
    logic [NUM_FAULTS-1:0] causeVec;
    logic [NUM_FAULTS-1:0] faultFlags;
    logic       wakeSync;
    logic       polSync;
    logic       monEnSync;
    logic       readFault;
    logic       wakeState;

    // Pins cross in from the analog side through two flops each
    assign rawIn = {forceSleep, loadMonitorEnable, wakePolarity, wakePin,
                    loadHeavy, extOvertemp, intOvertemp, dischargeShort,
                    dischargeOc, chargeOc};
    assign wakeSync  = state_reg.syncB[6];
    assign polSync   = state_reg.syncB[7];
    assign monEnSync = state_reg.syncB[8];
    assign readFault = regRead && (regAddr == OFS_FAULT_STATUS);

    // Wake bit is pin level xnor polarity
    assign wakeState = polSync ? wakeSync : !wakeSync;

    // Fault causes in bit order of the fault register
    assign causeVec[BIT_EXT_OVERTEMP] = state_reg.syncB[4];
    assign causeVec[BIT_INT_OVERTEMP] = state_reg.syncB[3];
    // Load fail needs monitoring on, a discharge event and heavy load
    assign causeVec[BIT_LOAD_FAIL] = state_reg.monOn &&
        state_reg.syncB[5] &&
        (state_reg.syncB[2] || state_reg.syncB[1]);
    assign causeVec[BIT_DIS_SHORT]   = state_reg.syncB[2];
    assign causeVec[BIT_DIS_OVERCUR] = state_reg.syncB[1];
    assign causeVec[BIT_CHG_OVERCUR] = state_reg.syncB[0];

    // ***************************************************************
    // Fault flags
    // ***************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < NUM_FAULTS; gi++) begin : gFault
            bafe_sticky_flag uFlag (
                .clk       (clk),
                .rst       (rst),
                .cause     (causeVec[gi]),
                .readClear (readFault),
                .flag      (faultFlags[gi])
            );
        end
    endgenerate

    // Next-state logic: synchronisers, writes, read data, decode
    always_comb begin
        state_next       = state_reg;
        state_next.syncA = rawIn;
        state_next.syncB = state_reg.syncA;
        // Monitor power tracks the software enable directly
        state_next.monOn = monEnSync;
        // Sleep request is deliberately not looked at here
        if (regWrite && regAddr == OFS_ANALOG_CONTROL) begin
            state_next.userFlags = {regWdata[BIT_USER_FLAG_B],
                                    regWdata[BIT_USER_FLAG_A]};
            state_next.muxSel = regWdata[3:0];
        end
        // Read data: reserved positions stay zero
        state_next.rdata = 8'h00;
        if (regRead) begin
            case (regAddr)
                OFS_CONFIG_STATUS: begin
                    state_next.rdata[BIT_SINGLE_UNIT] =
                        SINGLE_UNIT_VALUE;
                    state_next.rdata[BIT_WAKE_STATE] = wakeState;
                end
                OFS_FAULT_STATUS: begin
                    state_next.rdata[NUM_FAULTS-1:0] = faultFlags;
                end
                OFS_ANALOG_CONTROL: begin
                    state_next.rdata[BIT_USER_FLAG_B] =
                        state_reg.userFlags[1];
                    state_next.rdata[BIT_USER_FLAG_A] =
                        state_reg.userFlags[0];
                    state_next.rdata[3:0] = state_reg.muxSel;
                end
                default: begin
                    state_next.rdata = 8'h00;
                end
            endcase
        end
        // Selector decode: one route at most, reserved codes route nothing
        state_next.route    = '0;
        state_next.reserved = 1'b0;
        if (state_reg.muxSel <= MUX_INT_TEMP) begin
            state_next.route[state_reg.muxSel] = 1'b1;
        end else begin
            state_next.reserved = 1'b1;
        end
    end

    // The user flags sit on the backup rail, so only reset or an analog control write clears them
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg           <= '0;
            state_reg.userFlags <= USER_FLAG_RESET;
            state_reg.muxSel    <= MUX_RESET;
            state_reg.monOn     <= LOAD_MON_RESET;
            state_reg.route     <= bafe_route_t'(1);
        end else begin
            state_reg <= state_next;
        end
    end

    assign regRdata       = state_reg.rdata;
    assign loadMonitorOn  = state_reg.monOn;
    assign analogSelect   = state_reg.muxSel;
    assign analogRoute    = state_reg.route;
    assign analogReserved = state_reg.reserved;
    assign userFlags      = state_reg.userFlags;

    // ***************************************************************
    // Assertions
    // ***************************************************************
    property p_single_unit;
        @(posedge clk) disable iff (rst)
        (regRead && regAddr == OFS_CONFIG_STATUS)
            |=> regRdata[BIT_SINGLE_UNIT];
    endproperty
    a_single_unit: assert property (p_single_unit)
        else $error("single unit bit not read as one");

    property p_wake_pol;
        @(posedge clk) disable iff (rst)
        (regRead && regAddr == OFS_CONFIG_STATUS)
            |=> regRdata[BIT_WAKE_STATE] ==
                ($past(polSync) ~^ $past(wakeSync));
    endproperty
    a_wake_pol: assert property (p_wake_pol)
        else $error("wake bit does not follow polarity");

    property p_fault_read;
        @(posedge clk) disable iff (rst)
        readFault |=> regRdata[NUM_FAULTS-1:0] == $past(faultFlags);
    endproperty
    a_fault_read: assert property (p_fault_read)
        else $error("fault read data wrong");

    property p_ext_hot;
        @(posedge clk) disable iff (rst)
        $rose(extOvertemp) |-> ##3 faultFlags[BIT_EXT_OVERTEMP];
    endproperty
    a_ext_hot: assert property (p_ext_hot)
        else $error("external overtemp not latched in three cycles");

    property p_load_gate;
        @(posedge clk) disable iff (rst)
        (!state_reg.monOn && !faultFlags[BIT_LOAD_FAIL])
            |=> !faultFlags[BIT_LOAD_FAIL];
    endproperty
    a_load_gate: assert property (p_load_gate)
        else $error("load fail set while monitoring off");

    property p_user_write;
        @(posedge clk) disable iff (rst)
        (regWrite && regAddr == OFS_ANALOG_CONTROL)
            |=> userFlags == $past(regWdata[7:6]) &&
                analogSelect == $past(regWdata[3:0]);
    endproperty
    a_user_write: assert property (p_user_write)
        else $error("analog control write not stored");

    property p_route;
        @(posedge clk) disable iff (rst)
        ##1 $onehot0(analogRoute) &&
            (analogReserved == ($past(analogSelect) > MUX_INT_TEMP));
    endproperty
    a_route: assert property (p_route)
        else $error("selector decode wrong");

    property p_mon;
        @(posedge clk) disable iff (rst)
        $rose(loadMonitorEnable) |-> ##3 loadMonitorOn;
    endproperty
    a_mon: assert property (p_mon)
        else $error("load monitor not turned on");

    property p_sleep_keep;
        @(posedge clk) disable iff (rst)
        (forceSleep && !regWrite) |=> $stable(analogSelect);
    endproperty
    a_sleep_keep: assert property (p_sleep_keep)
        else $error("selector changed by sleep");
endmodule

// *** hw/bafe_pkg.sv ***
// Constants and types shared by the status and analog-mux register group
package bafe_pkg;
    // ***************************************************************
    // Register offsets
    // ***************************************************************
    localparam logic [7:0] OFS_CONFIG_STATUS  = 8'h00;
    localparam logic [7:0] OFS_FAULT_STATUS   = 8'h01;
    localparam logic [7:0] OFS_UNUSED         = 8'h02;
    localparam logic [7:0] OFS_ANALOG_CONTROL = 8'h03;
    // ***************************************************************
    // Field positions
    // ***************************************************************
    localparam int BIT_SINGLE_UNIT  = 5;
    localparam int BIT_WAKE_STATE   = 4;
    localparam int BIT_EXT_OVERTEMP = 5;
    localparam int BIT_INT_OVERTEMP = 4;
    localparam int BIT_LOAD_FAIL    = 3;
    localparam int BIT_DIS_SHORT    = 2;
    localparam int BIT_DIS_OVERCUR  = 1;
    localparam int BIT_CHG_OVERCUR  = 0;
    localparam int BIT_USER_FLAG_B  = 7;
    localparam int BIT_USER_FLAG_A  = 6;
    localparam int NUM_FAULTS       = 6;
    // ***************************************************************
    // Reset values and mux codes
    // ***************************************************************
    localparam logic       SINGLE_UNIT_VALUE = 1'b1;
    localparam logic [5:0] FAULT_RESET       = 6'h00;
    localparam logic [1:0] USER_FLAG_RESET   = 2'h0;
    localparam logic [3:0] MUX_RESET         = 4'h0;
    localparam logic [3:0] MUX_OFF           = 4'h0;
    localparam logic [3:0] MUX_CELL_LAST     = 4'h7;
    localparam logic [3:0] MUX_EXT_TEMP      = 4'h8;
    localparam logic [3:0] MUX_INT_TEMP      = 4'h9;
    localparam logic       LOAD_MON_RESET    = 1'b0;
    // Analog route one-hot: bit 0 off, 1..7 cells, 8 ext, 9 int
    localparam int         NUM_ROUTES        = 10;
    typedef logic [NUM_ROUTES-1:0] bafe_route_t;
endpackage

// *** hw/bafe_sticky_flag.sv ***
// One latched fault flag that clears on read only after its cause ends
`timescale 1ns/1ps
module bafe_sticky_flag (
    input  wire logic clk,        // 200 MHz clock
    input  wire logic rst,        // Synchronous reset, active high
    input  wire logic cause,      // Synchronised fault condition
    input  wire logic readClear,  // Status register read strobe
    output logic      flag        // Latched flag
);
    import bafe_pkg::*;

    typedef struct packed {
        logic flag;
    } bafe_flag_s;

    bafe_flag_s state_reg;
    bafe_flag_s state_next;

    // Live condition keeps the flag set, so a read during it never clears
    always_comb begin
        state_next = state_reg;
        if (cause) begin
            state_next.flag = 1'b1;
        end else if (readClear) begin
            state_next.flag = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign flag = state_reg.flag;

    property p_flag_holds;
        @(posedge clk) disable iff (rst)
        cause |=> flag;
    endproperty
    a_flag_holds: assert property (p_flag_holds)
        else $error("flag not set after cause");
    property p_flag_clear;
        @(posedge clk) disable iff (rst)
        (flag && !cause && readClear) |=> !flag;
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("flag not cleared by read");
endmodule

// *** sim/bafe_host_model.sv ***
// Pack controller model issuing single-byte register accesses
`timescale 1ns/1ps
module bafe_host_model (
    input  wire logic       clk,      // Block clock
    output logic [7:0]      regAddr,  // Register address
    output logic            regWrite, // Write strobe
    output logic [7:0]      regWdata, // Write data
    output logic            regRead,  // Read strobe
    input  wire logic [7:0] regRdata  // Read data
);
    // Idle bus: strobes low, released lines do not show a stale value
    initial begin
        regAddr  = 8'h00;
        regWdata = 8'h00;
        regWrite = 1'b0;
        regRead  = 1'b0;
    end
    // Write one byte; callers keep reserved bits zero, one call goes to OFS_UNUSED
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        regAddr  = a;
        regWdata = d;
        regWrite = 1'b1;
        @(posedge clk);
        #1;
        regWrite = 1'b0;
        regAddr  = ~a;
        regWdata = ~d;
        // Idle cycle, so a following call never re-drives in this step
        @(posedge clk);
        #1;
    endtask
    // Read one byte; data is registered, so it is taken after the edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        regAddr = a;
        regRead = 1'b1;
        @(posedge clk);
        #1;
        regRead = 1'b0;
        regAddr = ~a;
        d       = regRdata;
        // Idle cycle, so a following call never re-drives in this step
        @(posedge clk);
        #1;
    endtask
endmodule

// *** sim/tb_top.sv ***
// Self-checking bench for the status and analog selector registers
`timescale 1ns/1ps
module tb_top;
    import bafe_pkg::*;
    logic        clk, rst, wakePin, wakePolarity, loadHeavy, forceSleep;
    logic        loadMonitorEnable, regWrite, regRead, loadMonitorOn;
    logic        analogReserved;
    logic [5:0]  fault;
    logic [7:0]  regAddr, regWdata, regRdata, rdv;
    logic [3:0]  analogSelect;
    logic [1:0]  userFlags;
    bafe_route_t analogRoute;
    int          errors, n_checks;

    bafe_host_model bafe_host_model_inst (.clk(clk), .regAddr(regAddr),
        .regWrite(regWrite), .regWdata(regWdata), .regRead(regRead),
        .regRdata(regRdata));
    bafe_status_regs bafe_status_regs_inst (.clk(clk), .rst(rst),
        .regAddr(regAddr), .regWrite(regWrite), .regWdata(regWdata),
        .regRead(regRead), .regRdata(regRdata), .wakePin(wakePin),
        .wakePolarity(wakePolarity), .extOvertemp(fault[5]),
        .intOvertemp(fault[4]), .dischargeShort(fault[2]),
        .dischargeOc(fault[1]), .chargeOc(fault[0]), .loadHeavy(loadHeavy),
        .loadMonitorEnable(loadMonitorEnable), .forceSleep(forceSleep),
        .loadMonitorOn(loadMonitorOn), .analogSelect(analogSelect),
        .analogRoute(analogRoute), .analogReserved(analogReserved),
        .userFlags(userFlags));

    // ***************************************************************
    // Helpers
    // ***************************************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Inputs move 1 ns after the edge so sampling never races
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        bafe_host_model_inst.rd(a, rdv);
        chk(rdv, exp);
    endtask
    task automatic final_report;
        $display("checks=%0d errors=%0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ***************************************************************
    // Scenarios
    // ***************************************************************
    task automatic t_reset;
        chk(analogRoute, 16'h0001);
        chk({userFlags, analogSelect}, 16'h0000);
        chk(loadMonitorOn, 16'h0000);
        rdchk(8'h01, 8'h00);
        rdchk(8'h03, 8'h00);
    endtask
    // All wake polarity and pin pairs; fixed bit survives a write
    task automatic t_wake;
        for (int i = 0; i < 4; i++) begin
            wakePolarity = i[1];
            wakePin      = i[0];
            tick(3);
            rdchk(8'h00, {2'b00, 1'b1, ~(i[1] ^ i[0]), 4'h0});
        end
        bafe_host_model_inst.wr(8'h00, 8'h00);
        rdchk(8'h00, 8'h30);
        bafe_host_model_inst.wr(8'h02, 8'h00);
        rdchk(8'h02, 8'h00);
    endtask
    // A live cause survives reads; only a read after it ends clears
    task automatic t_faults;
        int bits[5] = '{5, 4, 2, 1, 0};
        foreach (bits[k]) begin
            fault[bits[k]] = 1'b1;
            tick(4);
            rdchk(8'h01, 8'h01 << bits[k]);
            rdchk(8'h01, 8'h01 << bits[k]);
            fault[bits[k]] = 1'b0;
            tick(3);
            rdchk(8'h01, 8'h01 << bits[k]);
            rdchk(8'h01, 8'h00);
        end
    endtask
    // Load fail needs the monitor on; short and overcurrent both feed it
    task automatic t_load;
        logic on;
        int   src;
        for (int p = 0; p < 3; p++) begin
            on  = (p < 2);
            src = (p == 1) ? 1 : 2;
            loadMonitorEnable = on;
            tick(4);
            chk(loadMonitorOn, on);
            loadHeavy  = 1'b1;
            fault[src] = 1'b1;
            tick(4);
            fault[src] = 1'b0;
            loadHeavy  = 1'b0;
            tick(3);
            rdchk(8'h01, {4'h0, on, 3'b000} | (8'h01 << src));
            rdchk(8'h01, 8'h00);
        end
    endtask
    // Every selector code, user flags alongside, then a forced sleep
    task automatic t_analog;
        logic [7:0]  d;
        bafe_route_t r;
        for (int i = 0; i < 16; i++) begin
            d = {i[1:0], 2'b00, i[3:0]};
            r = (i < 10) ? bafe_route_t'(1) << i : '0;
            bafe_host_model_inst.wr(8'h03, d);
            chk({userFlags, analogSelect}, {d[7:6], d[3:0]});
            tick(1);
            chk({analogReserved, analogRoute}, {i > 9, r});
            rdchk(8'h03, d);
        end
        forceSleep = 1'b1;
        tick(4);
        chk({userFlags, analogSelect}, 16'h003f);
        forceSleep = 1'b0;
        rdchk(8'h03, 8'hcf);
    endtask

    // Free-running 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Main sequence: quiet inputs, two-cycle reset, then scenarios
    initial begin
        {wakePin, wakePolarity, loadHeavy, forceSleep} = 4'h0;
        loadMonitorEnable = 1'b0;
        fault             = 6'h00;
        rst               = 1'b1;
        tick(2);
        rst = 1'b0;
        t_reset();
        t_wake();
        t_faults();
        t_load();
        t_analog();
        final_report();
    end
    // Watchdog: whole run needs well under 500 cycles
    initial begin
        #20000;
        errors++;
        final_report();
    end
endmodule
